// >>> verilog/slms_pkg.sv
// Shared constants, types and decode helpers of the link mode setup block
package slms_pkg;

    // ==================================================================
    // Bus geometry: printed offsets are word indexes, byte address = 4*idx
    localparam int          ADDR_W          = 13;
    localparam int          IDX_W           = 11;
    localparam logic [10:0] IDX_SYSREF      = 11'h084;
    localparam logic [10:0] IDX_CLK_POWER   = 11'h100;
    localparam logic [10:0] IDX_LINK_MODE   = 11'h110;
    localparam logic [10:0] IDX_INTERP      = 11'h111;
    localparam logic [10:0] IDX_LINK_CTRL   = 11'h300;
    localparam logic [10:0] IDX_SYNC_ERR    = 11'h312;
    localparam logic [10:0] IDX_LANE_CFG    = 11'h453;
    localparam logic [10:0] IDX_SUBCLASS    = 11'h458;
    localparam logic [10:0] IDX_DFR_RESET   = 11'h475;

    // ==================================================================
    // Field positions
    localparam int SYSREF_DC_BIT   = 6;
    localparam int SYSREF_RECEIVER_POWERDOWN_BIT   = 0;
    localparam int LMODE_DUAL_BIT  = 5;
    localparam int LMODE_BAD_BIT   = 7;
    localparam int LCTRL_DUAL_BIT  = 3;
    localparam int LCTRL_PAGE_BIT  = 2;
    localparam int LANE_SCR_BIT    = 7;
    localparam int DFR_RST_BIT     = 3;

    // ==================================================================
    // Writable masks, reset values and command values
    localparam logic [7:0] SYSREF_MASK     = 8'h41;
    localparam logic [7:0] LCTRL_MASK      = 8'h0F;
    localparam logic [7:0] RST_SYSREF      = 8'h00;
    localparam logic [7:0] RST_CLK_POWER   = 8'h01;
    localparam logic [5:0] RST_LINK_MODE   = 6'h00;
    localparam logic [7:0] RST_INTERP      = 8'h11;
    localparam logic [7:0] RST_LINK_CTRL   = 8'h00;
    localparam logic [7:0] RST_SYNC_ERR    = 8'h00;
    localparam logic [7:0] RST_LANE_CFG    = 8'h00;
    localparam logic [7:0] RST_SUBCLASS    = 8'h00;
    localparam logic [7:0] DFR_HOLD        = 8'h09;
    localparam logic [7:0] DFR_RELEASE     = 8'h01;
    localparam logic [7:0] CLK_ON_VALUE    = 8'h00;
    localparam logic [1:0] LINK_EN_DUAL    = 2'b11;
    localparam logic [4:0] MAX_SINGLE_MODE = 5'h16;
    localparam logic [4:0] MAX_DUAL_MODE   = 5'h16;

    // ==================================================================
    // State carriers
    typedef struct packed {
        logic [7:0]  sysref;
        logic [7:0]  clkpwr;
        logic [5:0]  lmode;
        logic        invalid;
        logic [7:0]  interp;
        logic [7:0]  lctl;
        logic [7:0]  syncerr;
        logic        clk_on;
        logic [1:0]  link_on;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } slms_top_t;

    typedef struct packed {
        logic [7:0] lane;
        logic [7:0] sub;
        logic [7:0] rst;
    } slms_bank_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic       busy;
        logic       sync_n;
    } slms_sync_t;

    // Word address match of a register index
    function automatic logic slms_hit(input logic [12:0] addr,
                                      input logic [10:0] idx);
        return addr == {idx, 2'b00};
    endfunction

    // Mode and interpolation combination check
    function automatic logic slms_combo_ok(input logic [5:0] mode,
                                           input logic [7:0] interp);
        logic main_ok;
        logic ch_ok;
        logic mode_ok;
        main_ok = interp[7:4] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC};
        ch_ok   = interp[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
        mode_ok = mode[5] ? (mode[4:0] <= MAX_DUAL_MODE)
                          : (mode[4:0] <= MAX_SINGLE_MODE);
        return main_ok & ch_ok & mode_ok;
    endfunction

endpackage

// >>> verilog/slms_deframer_bank.sv
// Per-link paged deframer settings and soft reset
`timescale 1ns/10ps
`default_nettype none
module slms_deframer_bank (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_lane,
    input  wire logic       wr_sub,
    input  wire logic       wr_rst,
    input  wire logic [7:0] wdata,
    output logic      [7:0] lane_ff,
    output logic      [7:0] sub_ff,
    output logic      [7:0] rst_ff,
    output logic            soft_rst
);
    import slms_pkg::*;

    slms_bank_t st_ff;
    slms_bank_t nxt_st;

    // ==================================================================
    // Settings are only taken on the strobe for this link
    always_comb begin
        nxt_st = st_ff;
        if (wr_lane) begin
            nxt_st.lane = wdata;
        end
        if (wr_sub) begin
            nxt_st.sub = wdata;
        end
        if (wr_rst) begin
            nxt_st.rst = wdata;
        end
    end

    // Deframer starts held in soft reset until software releases it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{lane: RST_LANE_CFG, sub: RST_SUBCLASS, rst: DFR_HOLD};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lane_ff  = st_ff.lane;
    assign sub_ff   = st_ff.sub;
    assign rst_ff   = st_ff.rst;
    assign soft_rst = st_ff.rst[DFR_RST_BIT];

    a_soft_reset_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_rst && wdata == DFR_HOLD) |=> soft_rst ##1 soft_rst || wr_rst)
        else $error("Deframer not held after hold write");
    a_soft_reset_rel: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_rst && wdata == DFR_RELEASE) |=> !soft_rst)
        else $error("Deframer not released after release write");
endmodule
`default_nettype wire

// >>> verilog/slms_sync_stretch.sv
// Sync output driver with programmable error indication length
`timescale 1ns/10ps
`default_nettype none
module slms_sync_stretch (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       link_up,
    input  wire logic       err,
    input  wire logic [3:0] duration,
    output logic            sync_n
);
    import slms_pkg::*;

    slms_sync_t st_ff;
    slms_sync_t nxt_st;

    // ==================================================================
    // Low while link is down; an error pulls it low duration+1 cycles
    always_comb begin
        nxt_st = st_ff;
        if (!link_up) begin
            nxt_st = '{cnt: 4'h0, busy: 1'b0, sync_n: 1'b0};
        end else if (err) begin
            nxt_st = '{cnt: duration, busy: 1'b1, sync_n: 1'b0};
        end else if (st_ff.busy && st_ff.cnt != 4'h0) begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
        end else begin
            nxt_st = '{cnt: 4'h0, busy: 1'b0, sync_n: 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{cnt: 4'h0, busy: 1'b0, sync_n: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_n = st_ff.sync_n;

    // Match ends on the third low cycle; the fourth must be high again
    a_sync_err_len: assert property (
        @(posedge clk) disable iff (!rst_n)
        (err && link_up && duration == 4'h2) ##1 (link_up && !err)[*3]
        |-> !sync_n && !$past(sync_n) && !$past(sync_n, 2) ##1 sync_n)
        else $error("Sync error indication length wrong");
    c_sync_err: cover property (@(posedge clk) disable iff (!rst_n)
        err && link_up ##1 !sync_n ##[1:16] sync_n);
endmodule
`default_nettype wire

// >>> verilog/slms_top.sv
// Link mode, interpolation, sysref and paged deframer setup registers
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Link mode bit 5 picks single-link (0) or dual-link (1)
// - Link mode bits 4:0 pick the lane operating mode
// - Link mode bit 7 reads 1 for an invalid mode/interpolation mix
// - Interpolation bits 7:4 hold the main datapath interpolation
// - Interpolation bits 3:0 hold the channel interpolation
// - Sysref bit 6 selects ac (0) or dc (1) coupled input
// - Sync error register upper nibble sets error indication length
// - Link control bit 2 selects which link's deframer is paged
// - Link enable field 01 runs one link, 11 runs both
// - Writing 0x09 holds deframer in soft reset, 0x01 releases it
// - Lane config bit 7 turns descrambling on
module slms_top (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [slms_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic      [31:0]               prdata,
    output logic                           pslverr,
    input  wire logic [1:0]                lane_err,
    output logic                           dp_clk_en,
    output logic                           dual_link,
    output logic      [4:0]                lane_mode,
    output logic      [3:0]                main_interp_setting,
    output logic      [3:0]                channel_interp_setting,
    output logic                           combo_invalid,
    output logic                           sysref_coupling_select,
    output logic                           sysref_receiver_powerdown,
    output logic      [3:0]                sync_err_duration,
    output logic      [1:0]                link_enable,
    output logic      [1:0]                descramble_en,
    output logic      [1:0][4:0]           lane_count_m1,
    output logic      [1:0][2:0]           subclass_field,
    output logic      [1:0][4:0]           sample_width_m1,
    output logic      [1:0]                deframer_in_reset,
    output logic      [1:0]                sync_output_n
);
    import slms_pkg::*;

    slms_top_t       st_ff;
    slms_top_t       nxt_st;
    logic            access;
    logic            wr;
    logic            miss;
    logic [7:0]      rd;
    logic            page;
    logic            hit_lane;
    logic            hit_sub;
    logic            hit_rst;
    logic [1:0]      wr_lane;
    logic [1:0]      wr_sub;
    logic [1:0]      wr_rst;
    logic [1:0][7:0] bk_lane;
    logic [1:0][7:0] bk_sub;
    logic [1:0][7:0] bk_rst;
    logic [1:0]      bk_soft;
    logic [1:0]      link_up;

    // ==================================================================
    // Bus phase decode
    // One wait state: answer is prepared in the first access cycle so
    // that read data and error both come straight from flops.
    assign access   = psel & penable;
    assign wr       = access & st_ff.pready & pwrite & ~st_ff.pslverr;
    assign page     = st_ff.lctl[LCTRL_PAGE_BIT];
    assign hit_lane = slms_hit(paddr, IDX_LANE_CFG);
    assign hit_sub  = slms_hit(paddr, IDX_SUBCLASS);
    assign hit_rst  = slms_hit(paddr, IDX_DFR_RESET);

    // ==================================================================
    // Read mux; unmapped addresses answer with an error and zero data
    always_comb begin
        rd   = 8'h00;
        miss = 1'b0;
        if (slms_hit(paddr, IDX_SYSREF)) begin
            rd = st_ff.sysref;
        end else if (slms_hit(paddr, IDX_CLK_POWER)) begin
            rd = st_ff.clkpwr;
        end else if (slms_hit(paddr, IDX_LINK_MODE)) begin
            rd = {st_ff.invalid, 1'b0, st_ff.lmode};
        end else if (slms_hit(paddr, IDX_INTERP)) begin
            rd = st_ff.interp;
        end else if (slms_hit(paddr, IDX_LINK_CTRL)) begin
            rd = st_ff.lctl;
        end else if (slms_hit(paddr, IDX_SYNC_ERR)) begin
            rd = st_ff.syncerr;
        end else if (hit_lane) begin
            rd = bk_lane[page];
        end else if (hit_sub) begin
            rd = bk_sub[page];
        end else if (hit_rst) begin
            rd = bk_rst[page];
        end else begin
            miss = 1'b1;
        end
    end

    // ==================================================================
    // Register updates and derived flags
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.pready = 1'b0;
        if (access && !st_ff.pready) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = miss;
            nxt_st.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
        end
        if (wr) begin
            if (slms_hit(paddr, IDX_SYSREF)) begin
                nxt_st.sysref = pwdata[7:0] & SYSREF_MASK;
            end
            if (slms_hit(paddr, IDX_CLK_POWER)) begin
                nxt_st.clkpwr = pwdata[7:0];
            end
            if (slms_hit(paddr, IDX_LINK_MODE)) begin
                nxt_st.lmode = pwdata[5:0];
            end
            if (slms_hit(paddr, IDX_INTERP)) begin
                nxt_st.interp = pwdata[7:0];
            end
            if (slms_hit(paddr, IDX_LINK_CTRL)) begin
                nxt_st.lctl = pwdata[7:0] & LCTRL_MASK;
            end
            if (slms_hit(paddr, IDX_SYNC_ERR)) begin
                nxt_st.syncerr = pwdata[7:0];
            end
        end
        // Flags are taken from the next settings, so they change on the same edge as a write
        nxt_st.invalid = ~slms_combo_ok(nxt_st.lmode, nxt_st.interp);
        nxt_st.clk_on  = (nxt_st.clkpwr == CLK_ON_VALUE);
        nxt_st.link_on = {nxt_st.lctl[1:0] == LINK_EN_DUAL,
                          nxt_st.lctl[0]};
    end

    // Datapath clocks stay off after reset until software powers them up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{sysref: RST_SYSREF, clkpwr: RST_CLK_POWER,
                       lmode: RST_LINK_MODE, invalid: 1'b0,
                       interp: RST_INTERP, lctl: RST_LINK_CTRL,
                       syncerr: RST_SYNC_ERR, clk_on: 1'b0,
                       link_on: 2'b00, pready: 1'b0, pslverr: 1'b0,
                       prdata: 32'h0000_0000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==================================================================
    // Per-link deframer banks and sync drivers
    // Page select steers writes so link 1 setup cannot disturb link 0.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_link
            assign wr_lane[gi] = wr & hit_lane & (page == gi);
            assign wr_sub[gi]  = wr & hit_sub  & (page == gi);
            assign wr_rst[gi]  = wr & hit_rst  & (page == gi);
            assign link_up[gi] = st_ff.link_on[gi] & ~bk_soft[gi];

            slms_deframer_bank u_bank (
                .clk      (clk),
                .rst_n    (rst_n),
                .wr_lane  (wr_lane[gi]),
                .wr_sub   (wr_sub[gi]),
                .wr_rst   (wr_rst[gi]),
                .wdata    (pwdata[7:0]),
                .lane_ff  (bk_lane[gi]),
                .sub_ff   (bk_sub[gi]),
                .rst_ff   (bk_rst[gi]),
                .soft_rst (bk_soft[gi])
            );

            slms_sync_stretch u_sync (
                .clk      (clk),
                .rst_n    (rst_n),
                .link_up  (link_up[gi]),
                .err      (lane_err[gi]),
                .duration (st_ff.syncerr[7:4]),
                .sync_n   (sync_output_n[gi])
            );

            assign descramble_en[gi]     = bk_lane[gi][LANE_SCR_BIT];
            assign lane_count_m1[gi]     = bk_lane[gi][4:0];
            assign subclass_field[gi]    = bk_sub[gi][7:5];
            assign sample_width_m1[gi]   = bk_sub[gi][4:0];
            assign deframer_in_reset[gi] = bk_soft[gi];
        end
    endgenerate

    // ==================================================================
    // Output taps, all from state flops
    assign pready                    = st_ff.pready;
    assign prdata                    = st_ff.prdata;
    assign pslverr                   = st_ff.pslverr;
    assign dp_clk_en                 = st_ff.clk_on;
    assign dual_link                 = st_ff.lmode[LMODE_DUAL_BIT];
    assign lane_mode                 = st_ff.lmode[4:0];
    assign main_interp_setting       = st_ff.interp[7:4];
    assign channel_interp_setting    = st_ff.interp[3:0];
    assign combo_invalid             = st_ff.invalid;
    assign sysref_coupling_select    = st_ff.sysref[SYSREF_DC_BIT];
    assign sysref_receiver_powerdown = st_ff.sysref[SYSREF_RECEIVER_POWERDOWN_BIT];
    assign sync_err_duration         = st_ff.syncerr[7:4];
    assign link_enable               = st_ff.link_on;

    // ==================================================================
    // Checks
    a_dual_link_sel: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && slms_hit(paddr, IDX_LINK_MODE))
        |=> dual_link == $past(pwdata[5]))
        else $error("Link arrangement not taken from write");
    a_lane_mode_sel: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && slms_hit(paddr, IDX_LINK_MODE)) ##1 1'b1
        |-> lane_mode == $past(pwdata[4:0]))
        else $error("Lane mode not taken from write");
    a_invalid_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 combo_invalid == !slms_combo_ok({dual_link, lane_mode},
                    {main_interp_setting, channel_interp_setting}))
        else $error("Invalid combination flag disagrees");
    a_invalid_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (access && !pready && !pwrite && slms_hit(paddr, IDX_LINK_MODE))
        |=> prdata[7] == combo_invalid)
        else $error("Invalid flag not read back in bit 7");
    a_main_interp: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && slms_hit(paddr, IDX_INTERP))
        |=> main_interp_setting == $past(pwdata[7:4]))
        else $error("Main interpolation not taken");
    a_chan_interp: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && slms_hit(paddr, IDX_INTERP))
        |=> channel_interp_setting == $past(pwdata[3:0]))
        else $error("Channel interpolation not taken");
    a_sysref_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && slms_hit(paddr, IDX_SYSREF))
        |=> sysref_coupling_select == $past(pwdata[6]))
        else $error("Sysref coupling not taken");
    a_page_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (access && !pready && !pwrite && hit_lane)
        |=> prdata[7:0] == $past(bk_lane[page]))
        else $error("Paged read from wrong link");
    a_page_route: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && hit_lane && !page) |=> $stable(bk_lane[1]))
        else $error("Write leaked into unselected link");
    // Link 1 setup must leave the link 0 settings untouched
    a_page_sub: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && hit_sub && page) |=> $stable(bk_sub[0]))
        else $error("Subclass write leaked into link 0");
    a_page_rst: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && hit_rst && page) |=> $stable(bk_rst[0]))
        else $error("Reset write leaked into link 0");
    a_link_enable: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && slms_hit(paddr, IDX_LINK_CTRL)) |=>
        link_enable == {$past(pwdata[1:0]) == LINK_EN_DUAL, $past(pwdata[0])})
        else $error("Link enables wrong");
    a_descramble: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr && hit_lane && !page) |=> descramble_en[0] == $past(pwdata[7]))
        else $error("Descrambling not taken");
    // A link that is down or held in soft reset keeps its sync request low
    a_sync_down: assert property (
        @(posedge clk) disable iff (!rst_n)
        !link_up[0] |=> !sync_output_n[0])
        else $error("Sync released while link 0 is down");

    c_dual_enabled: cover property (@(posedge clk) disable iff (!rst_n)
        link_enable == 2'b11 && dual_link);
    c_invalid_seen: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(combo_invalid));
    c_link1_release: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(deframer_in_reset[1]));
endmodule
`default_nettype wire

// >>> verif/slms_link_tx.sv
// Behavioural serial link transmitter that raises receive errors on demand
`timescale 1ns/10ps
`default_nettype none
module slms_link_tx (
    input  wire logic       clk,
    input  wire logic       rst_n,
    output logic      [1:0] lane_err
);
    // ==========================================================
    // Error event: one cycle, launched right after a rising edge
    task automatic inject(input int link);
        @(posedge clk);
        lane_err[link] <= 1'h1;
        @(posedge clk);
        lane_err[link] <= 1'h0;
    endtask
    // Quiet link until a test asks for an error
    initial lane_err = 2'h0;
endmodule
`default_nettype wire

// >>> verif/test_slms_top.sv
// Register, paging and sync tests of the link mode setup block
`timescale 1ns/10ps
`default_nettype none
module test_slms_top;
    import slms_pkg::*;
    // ==========================================================
    // Design signals and bench state
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] lane_err, link_enable, descramble_en;
    logic [1:0] deframer_in_reset, sync_output_n;
    logic dp_clk_en, dual_link, combo_invalid;
    logic sysref_coupling_select, sysref_receiver_powerdown;
    logic [4:0] lane_mode;
    logic [3:0] main_interp_setting, channel_interp_setting;
    logic [3:0] sync_err_duration;
    logic [1:0][4:0] lane_count_m1, sample_width_m1;
    logic [1:0][2:0] subclass_field;
    int err_count, num_checks, lows;

    slms_top slms_top_i (.*);
    slms_link_tx slms_link_tx_i (
        .clk      (clk),
        .rst_n    (rst_n),
        .lane_err (lane_err)
    );

    // ==========================================================
    // Clock, 20 ns period
    initial clk = 1'h0;
    always #10 clk = ~clk;

    task automatic chk(input string name, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the wait is bounded so a dead slave cannot hang us
    task automatic apb(input logic wr, input logic [10:0] idx,
                       input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        #1;
    endtask

    task automatic rdc(input logic [10:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {24'h0, exp}, rd);
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #200000;
        err_count++;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rdc(IDX_CLK_POWER, RST_CLK_POWER);
        rdc(IDX_DFR_RESET, DFR_HOLD);
        chk("dp_clk_en", 32'h0, dp_clk_en);
        apb(1'h1, IDX_CLK_POWER, CLK_ON_VALUE);
        chk("dp_clk_en", 32'h1, dp_clk_en);
        // Bad main and channel interpolation must raise the flag, a good pair clears it
        apb(1'h1, IDX_LINK_MODE, 8'h25);
        apb(1'h1, IDX_INTERP, 8'h55);
        rdc(IDX_LINK_MODE, 8'hA5);
        chk("combo_invalid", 32'h1, combo_invalid);
        apb(1'h1, IDX_INTERP, 8'h81);
        rdc(IDX_LINK_MODE, 8'h25);
        chk("mode", 32'h25, {dual_link, lane_mode});
        chk("interp", 32'h81,
            {main_interp_setting, channel_interp_setting});
        apb(1'h1, IDX_SYSREF, 8'hFF);
        rdc(IDX_SYSREF, SYSREF_MASK);
        chk("sysref", 32'h3,
            {sysref_coupling_select, sysref_receiver_powerdown});
        apb(1'h1, IDX_SYNC_ERR, 8'h20);
        chk("sync_err_duration", 32'h2, sync_err_duration);
        // Paged deframer setup, link 0 then link 1, links kept disabled
        for (int p = 0; p < 2; p++) begin
            apb(1'h1, IDX_LINK_CTRL, 8'(8 + 4 * p));
            apb(1'h1, IDX_DFR_RESET, DFR_HOLD);
            chk("in_reset", 32'h1, deframer_in_reset[p]);
            apb(1'h1, IDX_LANE_CFG, 8'h83 + 8'(p));
            apb(1'h1, IDX_SUBCLASS, 8'h2F - 8'(p));
            apb(1'h1, IDX_DFR_RESET, DFR_RELEASE);
            chk("lane", 32'h23 + p,
                {descramble_en[p], lane_count_m1[p]});
            chk("sub", 32'h2F - p,
                {subclass_field[p], sample_width_m1[p]});
            chk("resets", {p == 0, 1'h0}, deframer_in_reset);
        end
        chk("link0 lane", 32'h3, lane_count_m1[0]);
        rdc(IDX_LANE_CFG, 8'h84);
        apb(1'h1, IDX_LINK_CTRL, 8'h09);
        chk("link_enable", 32'h1, link_enable);
        rdc(IDX_LANE_CFG, 8'h83);
        apb(1'h1, IDX_LINK_CTRL, 8'h0B);
        chk("link_enable", 32'h3, link_enable);
        // Error on link 0 drops its sync for duration plus one cycles
        repeat (3) @(posedge clk);
        #1;
        chk("sync idle", 32'h3, sync_output_n);
        slms_link_tx_i.inject(0);
        lows = 0;
        repeat (8) begin
            #1;
            if (sync_output_n[0] === 1'h0) lows++;
            chk("sync link1", 32'h1, sync_output_n[1]);
            @(posedge clk);
        end
        chk("sync low cycles", 32'h3, lows);
        // Unmapped place: error response, no data
        apb(1'h1, 11'h001, 8'h5A);
        chk("pslverr", 32'h1, slverr);
        rdc(11'h001, 8'h00);
        chk("pslverr", 32'h1, slverr);
        end_sim();
    end
endmodule
`default_nettype wire
